// ### hdl/rilc_ctl.sv
`include "rilc_consts.svh"

module rilc_ctl #(
    parameter bit WDOG_RESET_EN = 1'b1,
    parameter bit EXT_LEVEL_EN  = 1'b1
) (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     clkEn,
    input  wire logic                     resetPin_b,
    input  wire logic                     extReqPin_b,
    input  wire logic                     wdogTimeout,
    input  wire logic                     modeStrap,
    input  wire rilc_pkg::rilc_core_req_t coreReq,
    input  wire rilc_pkg::rilc_tmr_flags_t tmrFlags,
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [7:0]               adr_i,
    input  wire logic [31:0]              dat_i,
    input  wire logic [3:0]               sel_i,
    output logic [31:0]                   dat_o,
    output logic                          ack_o,
    output logic                          cpuRst,
    output logic                          cpuHalt,
    output rilc_pkg::rilc_vec_t           vecOut,
    output logic                          maskFlag,
    output logic                          oscRun,
    output logic                          tmrCancel,
    output logic                          prescClr,
    output logic                          opMode
);

    rilc_pkg::rilc_state_t st_r;
    rilc_pkg::rilc_state_t stNxt;
    rilc_pkg::rilc_src_t   takeSrc;
    rilc_pkg::rilc_vec_t   vec_r;
    logic [11:0]           porCnt_r;
    logic                  rstVec;
    logic                  enterStop;
    logic                  enterWait;
    logic                  pinLow;
    logic                  wdogRst;
    logic                  rstEvt;
    logic                  extS1_r;
    logic                  extS2_r;
    logic                  extS3_r;
    logic                  extFall;
    logic                  extLatch_r;
    logic                  extReq;
    logic                  tmrReq;
    logic [2:0]            tmrEn_r;
    logic                  mask_r;
    logic [1:0]            cause_r;
    logic                  mode_r;
    logic                  cpuRst_r;
    logic                  cpuHalt_r;
    logic                  oscRun_r;
    logic                  tmrCancel_r;
    logic                  prescClr_r;
    logic                  ack_r;
    logic [31:0]           dat_r;
    logic                  wbHit;
    logic                  wbWrite;

    // priority pick at a boundary: unmasked hardware requests go ahead of a trap
    function automatic rilc_pkg::rilc_src_t pickSrc(input logic ext, input logic tmr,
                                                    input logic trap, input logic mask);
        if (!mask && ext) begin
            pickSrc = rilc_pkg::RILC_SRC_EXT;
        end else if (!mask && tmr) begin
            pickSrc = rilc_pkg::RILC_SRC_TMR;
        end else if (trap) begin
            pickSrc = rilc_pkg::RILC_SRC_TRAP;
        end else begin
            pickSrc = rilc_pkg::RILC_SRC_NONE;
        end
    endfunction

    assign pinLow  = !resetPin_b;
    assign extFall = extS3_r && !extS2_r;
    assign wdogRst = WDOG_RESET_EN && wdogTimeout && (st_r != rilc_pkg::RILC_ST_STOP);
    assign rstEvt  = pinLow || wdogRst;
    // level path waits one more stage so a fresh edge reaches the latch before the level is served
    assign extReq  = extLatch_r || (EXT_LEVEL_EN && !extS2_r && !extS3_r);
    assign tmrReq  = |(3'(tmrFlags) & tmrEn_r);
    assign wbHit   = cyc_i && stb_i && !ack_r;
    assign wbWrite = cyc_i && stb_i && we_i && ack_r;

    always_comb begin
        stNxt     = st_r;
        takeSrc   = rilc_pkg::RILC_SRC_NONE;
        rstVec    = 1'b0;
        enterStop = 1'b0;
        enterWait = 1'b0;
        case (st_r)
            rilc_pkg::RILC_ST_POR: begin
                if (porCnt_r == `RILC_POR_LAST) begin
                    stNxt = rilc_pkg::RILC_ST_HOLD;
                end
            end
            rilc_pkg::RILC_ST_HOLD: begin
                if (!pinLow) begin
                    stNxt  = rilc_pkg::RILC_ST_RUN;
                    rstVec = 1'b1;
                end
            end
            rilc_pkg::RILC_ST_RUN: begin
                if (coreReq.boundary) begin
                    takeSrc = pickSrc(extReq, tmrReq, coreReq.trapNext, mask_r);
                    if (takeSrc == rilc_pkg::RILC_SRC_NONE && coreReq.stopCmd) begin
                        enterStop = 1'b1;
                        stNxt     = rilc_pkg::RILC_ST_STOP;
                    end else if (takeSrc == rilc_pkg::RILC_SRC_NONE && coreReq.waitCmd) begin
                        enterWait = 1'b1;
                        stNxt     = rilc_pkg::RILC_ST_WAIT;
                    end
                end
            end
            rilc_pkg::RILC_ST_STOP: begin
                if (extReq) begin
                    takeSrc = pickSrc(1'b1, 1'b0, 1'b0, mask_r);
                    stNxt   = rilc_pkg::RILC_ST_RUN;
                end
            end
            rilc_pkg::RILC_ST_WAIT: begin
                if (extReq || tmrReq) begin
                    takeSrc = pickSrc(extReq, tmrReq, 1'b0, mask_r);
                    stNxt   = rilc_pkg::RILC_ST_RUN;
                end
            end
            default: begin
                stNxt = rilc_pkg::RILC_ST_POR;
            end
        endcase
        if (st_r != rilc_pkg::RILC_ST_POR && rstEvt) begin
            stNxt     = rilc_pkg::RILC_ST_HOLD;
            takeSrc   = rilc_pkg::RILC_SRC_NONE;
            rstVec    = 1'b0;
            enterStop = 1'b0;
            enterWait = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= rilc_pkg::RILC_ST_POR;
        end else if (clkEn) begin
            st_r <= stNxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            porCnt_r <= 12'h000;
        end else if (clkEn && st_r == rilc_pkg::RILC_ST_POR && porCnt_r != `RILC_POR_LAST) begin
            porCnt_r <= porCnt_r + 12'h001;
        end
    end

    // reset cause and mode; a watchdog reset leaves the mode alone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cause_r <= `RILC_CAUSE_POR;
            mode_r  <= 1'b0;
        end else if (clkEn) begin
            if (st_r != rilc_pkg::RILC_ST_POR && pinLow) begin
                cause_r <= `RILC_CAUSE_PIN;
            end else if (st_r != rilc_pkg::RILC_ST_POR && wdogRst) begin
                cause_r <= `RILC_CAUSE_WDOG;
            end
            if (rstVec && cause_r != `RILC_CAUSE_WDOG) begin
                mode_r <= modeStrap;
            end
        end
    end

    // request pin synchroniser and falling-edge latch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            extS1_r <= 1'b1;
            extS2_r <= 1'b1;
            extS3_r <= 1'b1;
        end else if (clkEn) begin
            extS1_r <= extReqPin_b;
            extS2_r <= extS1_r;
            extS3_r <= extS2_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            extLatch_r <= 1'b0;
        end else if (clkEn) begin
            if (extFall) begin
                extLatch_r <= 1'b1;
            end else if (takeSrc == rilc_pkg::RILC_SRC_EXT || stNxt == rilc_pkg::RILC_ST_HOLD) begin
                extLatch_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_r <= 1'b1;
        end else if (clkEn) begin
            if (stNxt == rilc_pkg::RILC_ST_HOLD || rstVec) begin
                mask_r <= 1'b1;
            end else if (takeSrc != rilc_pkg::RILC_SRC_NONE) begin
                mask_r <= 1'b1;
            end else if (enterStop || enterWait) begin
                mask_r <= 1'b0;
            end else if (st_r == rilc_pkg::RILC_ST_RUN && coreReq.trapReturn) begin
                mask_r <= coreReq.maskPopped;
            end else if (st_r == rilc_pkg::RILC_ST_RUN && coreReq.setMask) begin
                mask_r <= 1'b1;
            end else if (st_r == rilc_pkg::RILC_ST_RUN && coreReq.clrMask) begin
                mask_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_r <= '0;
        end else if (clkEn) begin
            vec_r.valid    <= rstVec || (takeSrc != rilc_pkg::RILC_SRC_NONE);
            vec_r.pushRegs <= (takeSrc != rilc_pkg::RILC_SRC_NONE);
            case (takeSrc)
                rilc_pkg::RILC_SRC_EXT:  vec_r.addr <= `RILC_VEC_EXT;
                rilc_pkg::RILC_SRC_TMR:  vec_r.addr <= `RILC_VEC_TIMER;
                rilc_pkg::RILC_SRC_TRAP: vec_r.addr <= `RILC_VEC_TRAP;
                default:                 vec_r.addr <= `RILC_VEC_RESET;
            endcase
        end
    end

    // mode outputs; the one-cycle pulses stretch while clkEn is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuRst_r    <= 1'b1;
            cpuHalt_r   <= 1'b0;
            oscRun_r    <= 1'b1;
            tmrCancel_r <= 1'b0;
            prescClr_r  <= 1'b0;
        end else if (clkEn) begin
            cpuRst_r    <= (stNxt == rilc_pkg::RILC_ST_POR) || (stNxt == rilc_pkg::RILC_ST_HOLD);
            cpuHalt_r   <= (stNxt == rilc_pkg::RILC_ST_STOP) || (stNxt == rilc_pkg::RILC_ST_WAIT);
            oscRun_r    <= (stNxt != rilc_pkg::RILC_ST_STOP);
            tmrCancel_r <= enterStop;
            prescClr_r  <= enterStop;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tmrEn_r <= `RILC_CTRL_RESET;
        end else if (clkEn) begin
            if (enterStop || stNxt == rilc_pkg::RILC_ST_HOLD) begin
                tmrEn_r <= `RILC_CTRL_RESET;
            end else if (wbWrite && sel_i[0] && adr_i == `RILC_OFS_CTRL) begin
                tmrEn_r <= dat_i[`RILC_CTRL_TEN_MSB:`RILC_CTRL_TEN_LSB];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (clkEn) begin
            ack_r <= wbHit;
            if (wbHit) begin
                dat_r <= 32'h0000_0000;
                if (adr_i == `RILC_OFS_CTRL) begin
                    dat_r[`RILC_CTRL_TEN_MSB:`RILC_CTRL_TEN_LSB] <= tmrEn_r;
                end else if (adr_i == `RILC_OFS_STATUS) begin
                    dat_r[`RILC_STAT_MASK]  <= mask_r;
                    dat_r[`RILC_STAT_LATCH] <= extLatch_r;
                    dat_r[`RILC_STAT_TREQ]  <= tmrReq;
                    dat_r[`RILC_STAT_STOP]  <= (st_r == rilc_pkg::RILC_ST_STOP);
                    dat_r[`RILC_STAT_WAIT]  <= (st_r == rilc_pkg::RILC_ST_WAIT);
                    dat_r[`RILC_STAT_CAUSE_MSB:`RILC_STAT_CAUSE_LSB] <= cause_r;
                    dat_r[`RILC_STAT_MODE]  <= mode_r;
                end
            end
        end
    end

    assign dat_o     = dat_r;
    assign ack_o     = ack_r;
    assign cpuRst    = cpuRst_r;
    assign cpuHalt   = cpuHalt_r;
    assign vecOut    = vec_r;
    assign maskFlag  = mask_r;
    assign oscRun    = oscRun_r;
    assign tmrCancel = tmrCancel_r;
    assign prescClr  = prescClr_r;
    assign opMode    = mode_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence seqStopEntry;
        clkEn && enterStop ##1 1'b1;
    endsequence

    sequence seqStopSettled;
        !oscRun_r && tmrEn_r == 3'h0 && !mask_r && tmrCancel_r && prescClr_r && cpuHalt_r;
    endsequence

    AST_PIN_RESET: assert property (clkEn && pinLow && st_r != rilc_pkg::RILC_ST_POR |=> cpuRst_r)
        else $error("reset pin low did not hold the core in reset");
    AST_POR_COUNT: assert property (st_r == rilc_pkg::RILC_ST_POR && porCnt_r < `RILC_POR_LAST
                                    |=> st_r == rilc_pkg::RILC_ST_POR && cpuRst_r)
        else $error("power-up delay ended early");
    AST_RESET_VECTOR: assert property ($fell(cpuRst_r) |-> vec_r.valid && !vec_r.pushRegs
                                       && vec_r.addr == `RILC_VEC_RESET && mask_r && $past(resetPin_b))
        else $error("reset release without reset vector and mask set");
    AST_WDOG_MODE: assert property (clkEn && wdogRst && !pinLow && st_r != rilc_pkg::RILC_ST_POR
                                    |=> cpuRst_r && $stable(mode_r))
        else $error("watchdog reset missing or mode changed");
    AST_TAKE_MASK: assert property (vec_r.pushRegs |-> vec_r.valid && mask_r)
        else $error("interrupt taken without setting mask");
    AST_MASKED_HOLD: assert property (clkEn && mask_r && st_r == rilc_pkg::RILC_ST_RUN && !rstEvt
                                      |=> !(vec_r.pushRegs && vec_r.addr != `RILC_VEC_TRAP))
        else $error("hardware interrupt taken while masked");
    AST_EXT_FIRST: assert property (clkEn && st_r == rilc_pkg::RILC_ST_RUN && coreReq.boundary && !rstEvt
                                    && !mask_r && extReq && tmrReq |=> vec_r.addr == `RILC_VEC_EXT)
        else $error("timer served before external request");
    AST_LATCH_CLEAR: assert property (clkEn && takeSrc == rilc_pkg::RILC_SRC_EXT && !extFall
                                      |=> !extLatch_r ##1 (!$past(clkEn) || !$past(extFall) || extLatch_r))
        else $error("request latch not cleared or new edge lost");
    AST_STOP_ENTRY: assert property (seqStopEntry |-> seqStopSettled)
        else $error("stop entry did not settle timer, mask and oscillator");
    AST_WAIT_EXIT: assert property (clkEn && st_r == rilc_pkg::RILC_ST_WAIT && !rstEvt
                                    && (extReq || tmrReq) |=> !cpuHalt_r && vec_r.pushRegs)
        else $error("wait state not left on interrupt");
    AST_WAIT_MASK: assert property (clkEn && enterWait |=> !mask_r && cpuHalt_r ##0 oscRun_r)
        else $error("wait entry did not clear the mask");

endmodule

// ### hdl/rilc_consts.svh
`ifndef RILC_CONSTS_SVH
`define RILC_CONSTS_SVH

// oscillator stabilisation time, in processor clock cycles (1 cycle = 10 ns)
`define RILC_POR_CYCLES     12'd4064
`define RILC_POR_LAST       (`RILC_POR_CYCLES - 12'd1)

// vector addresses
`define RILC_VEC_RESET      16'h1ffe
`define RILC_VEC_TRAP       16'h1ffc
`define RILC_VEC_EXT        16'h1ffa
`define RILC_VEC_TIMER      16'h1ff8

// register byte offsets
`define RILC_OFS_CTRL       8'h00
`define RILC_OFS_STATUS     8'h04

// control register fields
`define RILC_CTRL_TEN_LSB   0
`define RILC_CTRL_TEN_MSB   2
`define RILC_CTRL_RESET     3'h0

// status register fields
`define RILC_STAT_MASK      0
`define RILC_STAT_LATCH     1
`define RILC_STAT_TREQ      2
`define RILC_STAT_STOP      3
`define RILC_STAT_WAIT      4
`define RILC_STAT_CAUSE_LSB 5
`define RILC_STAT_CAUSE_MSB 6
`define RILC_STAT_MODE      7

// reset cause codes
`define RILC_CAUSE_POR      2'h0
`define RILC_CAUSE_PIN      2'h1
`define RILC_CAUSE_WDOG     2'h2

`endif

// ### hdl/rilc_pkg.sv
package rilc_pkg;

    typedef enum logic [2:0] {
        RILC_ST_POR,
        RILC_ST_HOLD,
        RILC_ST_RUN,
        RILC_ST_STOP,
        RILC_ST_WAIT
    } rilc_state_t;

    typedef enum logic [1:0] {
        RILC_SRC_NONE,
        RILC_SRC_EXT,
        RILC_SRC_TMR,
        RILC_SRC_TRAP
    } rilc_src_t;

    // requests from the instruction sequencer
    typedef struct packed {
        logic boundary;
        logic trapNext;
        logic trapReturn;
        logic maskPopped;
        logic stopCmd;
        logic waitCmd;
        logic setMask;
        logic clrMask;
    } rilc_core_req_t;

    typedef struct packed {
        logic captureEventFlag;
        logic compareMatchFlag;
        logic counterWrapFlag;
    } rilc_tmr_flags_t;

    typedef struct packed {
        logic        valid;
        logic        pushRegs;
        logic [15:0] addr;
    } rilc_vec_t;

endpackage

// ### verif/rilc_far_model.sv
module rilc_far_model (
    input  wire logic                 clk,
    input  wire logic                 tmrCancel,
    output logic                      resetPin_b,
    output logic                      extReqPin_b,
    output logic                      wdogTimeout,
    output rilc_pkg::rilc_tmr_flags_t tmrFlags
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        resetPin_b = 1'b1;
        extReqPin_b = 1'b1;
        wdogTimeout = 1'b0;
        tmrFlags = '0;
    end

    // the timer drops its pending flags when told to cancel
    always @(posedge clk) begin
        if (tmrCancel === 1'b1) begin
            tmrFlags <= '0;
        end
    end

    // caller keeps the pin low for whole cycles, never a fraction
    task automatic hold_pin(input logic low);
        resetPin_b <= !low;
    endtask

    // one-cycle low pulse: a single falling edge
    task automatic ext_pulse();
        extReqPin_b <= 1'b0;
        @(posedge clk);
        extReqPin_b <= 1'b1;
    endtask

    task automatic wdog_pulse();
        wdogTimeout <= 1'b1;
        @(posedge clk);
        wdogTimeout <= 1'b0;
    endtask

    task automatic set_flags(input logic [2:0] f);
        tmrFlags <= f;
    endtask
endmodule

// ### verif/test_reset_interrupt_lowpower_ctl.sv
`include "rilc_consts.svh"
module test_reset_interrupt_lowpower_ctl;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      clk = 1'b0;
    logic                      rst_b = 1'b0;
    logic                      cyc = 1'b0;
    logic                      stb = 1'b0;
    logic                      we = 1'b0;
    logic [7:0]                adr = 8'h00;
    logic [31:0]               wdat = 32'h0;
    logic [3:0]                sel = 4'h0;
    logic                      modeStrap = 1'b0;
    logic                      clkEn = 1'b1;
    logic [3:0]                wbSel = 4'hf;
    rilc_pkg::rilc_core_req_t  coreReq = '0;
    logic                      resetPin_b, extReqPin_b, wdogTimeout;
    rilc_pkg::rilc_tmr_flags_t tmrFlags;
    logic [31:0]               dat_o, rd;
    logic                      ack_o, cpuRst, cpuHalt, maskFlag, oscRun, tmrCancel, prescClr, opMode;
    rilc_pkg::rilc_vec_t       vecOut;
    int                        errCount = 0;
    int                        nCompared = 0;
    localparam logic [7:0]     BND = 8'h80;

    always #5 clk = ~clk;

    rilc_far_model rilc_far_model_i (.clk(clk), .tmrCancel(tmrCancel), .resetPin_b(resetPin_b),
        .extReqPin_b(extReqPin_b), .wdogTimeout(wdogTimeout), .tmrFlags(tmrFlags));

    rilc_ctl rilc_ctl_i (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .resetPin_b(resetPin_b),
        .extReqPin_b(extReqPin_b), .wdogTimeout(wdogTimeout), .modeStrap(modeStrap),
        .coreReq(coreReq), .tmrFlags(tmrFlags), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(wdat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o), .cpuRst(cpuRst), .cpuHalt(cpuHalt),
        .vecOut(vecOut), .maskFlag(maskFlag), .oscRun(oscRun), .tmrCancel(tmrCancel),
        .prescClr(prescClr), .opMode(opMode));

    task automatic finish_test();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // waits at most n edges for the vector pulse, then compares it
    task automatic chk_vec(input logic [15:0] a, input logic push, input int n);
        int i;
        for (i = 0; i < n && vecOut.valid !== 1'b1; i++) begin
            @(posedge clk);
        end
        chk(32'(vecOut), 32'({1'b1, push, a}), "vector");
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wbSel;
        do @(posedge clk); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    // bits of coreReq: boundary,trapNext,trapReturn,maskPopped,stopCmd,waitCmd,setMask,clrMask
    task automatic core(input logic [7:0] r);
        coreReq <= r;
        @(posedge clk);
        coreReq <= '0;
    endtask

    task automatic por(input logic pinLow);
        rst_b <= 1'b0;
        rilc_far_model_i.hold_pin(pinLow);
        repeat (4) @(posedge clk);
        chk(32'({cpuRst, maskFlag}), 32'h3, "in reset");
        rst_b <= 1'b1;
        repeat (4060) @(posedge clk);
        chk(32'(cpuRst), 32'h1, "por delay");
        if (pinLow) begin
            repeat (30) @(posedge clk);
            chk(32'(cpuRst), 32'h1, "pin low after delay");
            rilc_far_model_i.hold_pin(1'b0);
        end
        chk_vec(`RILC_VEC_RESET, 1'b0, 20);
        chk(32'({cpuRst, maskFlag}), 32'h1, "out of reset");
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        finish_test();
    end

    initial begin
        por(1'b0);
        wb(1'b0, `RILC_OFS_STATUS, 32'h0);
        chk(rd, 32'h1, "status after por");
        wb(1'b1, `RILC_OFS_CTRL, 32'h7);
        // a write without the low byte lane, and one to an unmapped offset, must both be dropped
        wbSel = 4'he;
        wb(1'b1, `RILC_OFS_CTRL, 32'hffff_fff0);
        wbSel = 4'hf;
        wb(1'b1, 8'hfc, 32'hffff_ffff);
        wb(1'b0, `RILC_OFS_CTRL, 32'h0);
        chk(rd, 32'h7, "ctrl");
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0, "unmapped");
        // a mask clear offered while frozen must be lost
        clkEn <= 1'b0;
        core(8'h01);
        @(posedge clk);
        chk(32'(maskFlag), 32'h1, "frozen");
        clkEn <= 1'b1;
        rilc_far_model_i.set_flags(3'b010);
        rilc_far_model_i.ext_pulse();
        core(8'h01);
        repeat (4) @(posedge clk);
        core(BND);
        chk_vec(`RILC_VEC_EXT, 1'b1, 3);
        chk(32'(maskFlag), 32'h1, "mask on entry");
        core(8'h01);
        core(BND);
        chk_vec(`RILC_VEC_TIMER, 1'b1, 3);
        rilc_far_model_i.set_flags(3'b000);
        rilc_far_model_i.ext_pulse();
        repeat (4) @(posedge clk);
        core(BND);
        @(posedge clk);
        chk(32'(vecOut.valid), 32'h0, "masked request");
        core(BND | 8'h40);
        chk_vec(`RILC_VEC_TRAP, 1'b1, 3);
        core(8'h20);
        @(posedge clk);
        chk(32'(maskFlag), 32'h0, "return restores mask");
        wb(1'b0, `RILC_OFS_STATUS, 32'h0);
        chk(rd, 32'h2, "request pending");
        core(8'h01);
        core(BND);
        chk_vec(`RILC_VEC_EXT, 1'b1, 3);
        wb(1'b0, `RILC_OFS_STATUS, 32'h0);
        chk(rd, 32'h1, "latch cleared");
        core(8'h01);
        core(BND | 8'h08);
        @(posedge clk);
        chk(32'({cpuHalt, oscRun, tmrCancel, prescClr, maskFlag}), 32'h16, "stop entry");
        wb(1'b0, `RILC_OFS_CTRL, 32'h0);
        chk(rd, 32'h0, "enables off");
        rilc_far_model_i.set_flags(3'b111);
        rilc_far_model_i.wdog_pulse();
        repeat (5) @(posedge clk);
        chk(32'({cpuHalt, cpuRst}), 32'h2, "stays stopped");
        rilc_far_model_i.set_flags(3'b000);
        rilc_far_model_i.ext_pulse();
        chk_vec(`RILC_VEC_EXT, 1'b1, 10);
        chk(32'({cpuHalt, oscRun}), 32'h1, "stop exit");
        core(8'h02);
        core(BND | 8'h04);
        @(posedge clk);
        chk(32'({cpuHalt, maskFlag, oscRun}), 32'h5, "wait entry");
        wb(1'b1, `RILC_OFS_CTRL, 32'h1);
        rilc_far_model_i.set_flags(3'b001);
        chk_vec(`RILC_VEC_TIMER, 1'b1, 10);
        rilc_far_model_i.set_flags(3'b000);
        modeStrap <= 1'b1;
        core(BND | 8'h04);
        rilc_far_model_i.wdog_pulse();
        chk_vec(`RILC_VEC_RESET, 1'b0, 5);
        chk(32'({opMode, cpuHalt, maskFlag}), 32'h1, "watchdog reset");
        rilc_far_model_i.hold_pin(1'b1);
        repeat (3) @(posedge clk);
        chk(32'(cpuRst), 32'h1, "pin reset");
        rilc_far_model_i.hold_pin(1'b0);
        @(posedge clk);
        chk_vec(`RILC_VEC_RESET, 1'b0, 2);
        wb(1'b0, `RILC_OFS_STATUS, 32'h0);
        chk(rd, 32'ha1, "pin cause and mode");
        por(1'b1);
        finish_test();
    end
endmodule
